// file: hdl/blt_pkg.sv
package blt_pkg;
	// ==========================================
	// register map (byte addresses)
	localparam logic [7:0] OFF_GPR0 = 8'h00;
	localparam logic [7:0] OFF_WIDTH = 8'h20;
	localparam logic [7:0] OFF_INSTR = 8'h24;
	localparam logic [7:0] OFF_STAT = 8'h28;
	localparam int GPR_IDX_HI = 4;
	localparam int GPR_IDX_LO = 2;
	// status bits
	localparam int STAT_LFLAG = 0;
	localparam int STAT_BUSY = 1;
	// ==========================================
	// instruction word fields
	localparam logic [7:0] MASKED_CODE = 8'h0E;
	localparam logic [7:0] WT_CODE = 8'h1E;
	localparam logic [7:0] EXT_CODE = 8'h2E;
	localparam logic [7:0] PAT_CODE = 8'h3E;
	localparam int DIR_BIT = 17;
	localparam int SEL_BIT = 16;
	localparam int INV_BIT = 15;
	localparam int OP_HI = 13;
	localparam int OP_LO = 10;
	localparam int SZ_HI = 9;
	localparam int SZ_LO = 8;
	// operation and size field codes
	localparam logic [3:0] OP_AND = 4'hA;
	localparam logic [3:0] OP_OR = 4'h6;
	localparam logic [3:0] OP_XOR = 4'hE;
	localparam logic [3:0] OP_FOR = 4'hC;
	localparam logic [3:0] OP_COPY = 4'h4;
	localparam logic [1:0] SZ_BYTE = 2'h0;
	localparam logic [1:0] SZ_WORD = 2'h1;
	localparam logic [1:0] SZ_DWORD = 2'h3;
	// ==========================================
	// data path constants
	localparam int WORD_W = 16;
	localparam logic [31:0] STEP_WORD = 32'h0000_0002;
	localparam logic [15:0] MASK_ALL = 16'hFFFF;
	// engine kinds
	typedef enum logic [2:0]
	{
		K_NONE = 3'b000,
		K_MASK = 3'b001,
		K_WT = 3'b010,
		K_EXT = 3'b011,
		K_PAT = 3'b100
	} kind_t;
endpackage

// file: hdl/bitblt_pattern_instr_unit.sv
// Local design decisions: the address map and the AHB-Lite register port.
`timescale 1ns/1ns
// What this block does
// - masked ops take operands from R0-stack top
// - functions AND OR XOR fast-OR copy
// - increasing address default, decreasing walks backward
// - inverted option complements source before combining
// - fast OR ignores invert and decreasing options
// - direction and source options each exclusive
// - width counts source words per line
// - odd byte source warp accepted
// - vertical direction from warp signs
// - decode direction, invert, AND selector bits
// - op and size field codes per function
// - word transfer ORs, stores, advances by two
// - word transfer shifts source up
// - external transfer register roles
// - external transfer final register values
// - source read, dest read, dest write cycles
// - external horizontal direction sign
// - preload source read when L flag clear
// - pattern store repeats times, steps
// - pattern store leaves zero, R0 last
// - zero mask bits leave destination unchanged
// - edge masks constant for whole operation
module bitblt_pattern_instr_unit
(
	// clock and reset
	input wire logic CORE_CLK_I,
	input wire logic RST_N_I,
	// ahb-lite slave
	input wire logic HSEL_I,
	input wire logic [31:0] HADDR_I,
	input wire logic [1:0] HTRANS_I,
	input wire logic HWRITE_I,
	input wire logic [2:0] HSIZE_I,
	input wire logic [31:0] HWDATA_I,
	input wire logic HREADY_I,
	output logic [31:0] HRDATA_O,
	output logic HREADYOUT_O,
	output logic HRESP_O,
	// memory master
	output logic MEM_REQ_O,
	output logic MEM_WE_O,
	output logic [31:0] MEM_ADDR_O,
	output logic [1:0] MEM_SIZE_O,
	output logic [31:0] MEM_WDATA_O,
	input wire logic [31:0] MEM_RDATA_I,
	input wire logic MEM_ACK_I,
	// combined data from the external blit unit
	input wire logic [15:0] BLIT_DATA_I,
	// engine state
	output logic BUSY_O
);
	// ==========================================
	// state and storage
	typedef enum logic [3:0]
	{
		S_IDLE = 4'b0000,
		S_LINE = 4'b0001,
		S_PRE = 4'b0010,
		S_SRC = 4'b0011,
		S_DRD = 4'b0100,
		S_DRD_HI = 4'b0101,
		S_DWR = 4'b0110,
		S_DWR_HI = 4'b0111,
		S_EOL = 4'b1000,
		S_PAT = 4'b1001
	} state_t;

	state_t state_q; // engine state
	blt_pkg::kind_t kind_q; // running instruction
	logic [31:0] gpr_q [8]; // general registers R0..
	logic [15:0] width_q; // stack top word count
	logic lflag_q; // status L flag
	logic [3:0] op_q; // combining function
	logic dec_q; // walk backward
	logic inv_q; // complement source
	logic [1:0] psize_q; // pattern store size
	logic [15:0] wcnt_q; // words left in line
	logic first_q; // first word of line
	logic [15:0] src_q; // last source word
	logic [15:0] carry_q; // previous source word
	logic [15:0] dst_q; // destination low word
	logic [15:0] dhi_q; // destination high word
	logic wr_pend_q; // ahb write in data phase
	logic [7:0] waddr_q; // ahb data phase address
	logic [31:0] hrdata_q; // ahb read data
	logic ahb_go; // address phase accepted
	logic ack; // memory access done
	logic start; // instruction word written
	blt_pkg::kind_t new_kind; // decoded kind
	logic [15:0] mask_w; // edge mask of this word
	logic [15:0] aligned; // shifted source
	logic [15:0] merged; // masked result
	logic [31:0] wt_res; // word transfer result
	logic [31:0] step; // per word address step

	// ==========================================
	// functions
	// decode the instruction word into its kind
	function automatic blt_pkg::kind_t decode(input logic [31:0] w);
		logic [3:0] op;
		logic [1:0] sz;
		op = w[blt_pkg::OP_HI:blt_pkg::OP_LO];
		sz = w[blt_pkg::SZ_HI:blt_pkg::SZ_LO];
		decode = blt_pkg::K_NONE;
		case (w[7:0])
			blt_pkg::MASKED_CODE:
			begin
				if (op == blt_pkg::OP_AND && sz == blt_pkg::SZ_DWORD && w[blt_pkg::SEL_BIT])
					decode = blt_pkg::K_MASK;
				else if (sz == blt_pkg::SZ_WORD && !w[blt_pkg::SEL_BIT] &&
					(op == blt_pkg::OP_OR || op == blt_pkg::OP_XOR ||
					op == blt_pkg::OP_FOR || op == blt_pkg::OP_COPY))
					decode = blt_pkg::K_MASK;
			end
			blt_pkg::WT_CODE: decode = blt_pkg::K_WT;
			blt_pkg::EXT_CODE: decode = blt_pkg::K_EXT;
			blt_pkg::PAT_CODE: decode = blt_pkg::K_PAT;
			default: decode = blt_pkg::K_NONE;
		endcase
	endfunction

	// combine source with destination
	function automatic logic [15:0] combine(input logic [3:0] op, input logic [15:0] s,
		input logic [15:0] d);
		case (op)
			blt_pkg::OP_AND: combine = s & d;
			blt_pkg::OP_XOR: combine = s ^ d;
			blt_pkg::OP_COPY: combine = s;
			default: combine = s | d;
		endcase
	endfunction

	// ==========================================
	// ahb-lite slave, zero wait states
	assign ahb_go = HSEL_I && HTRANS_I[1] && HREADY_I;
	assign HREADYOUT_O = 1'b1;
	assign HRESP_O = 1'b0;
	assign HRDATA_O = hrdata_q;
	assign start = wr_pend_q && waddr_q == blt_pkg::OFF_INSTR && state_q == S_IDLE;
	assign new_kind = decode(HWDATA_I);
	assign BUSY_O = state_q != S_IDLE;

	// capture the address phase and prepare read data
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			wr_pend_q <= 1'b0;
			waddr_q <= 8'h00;
			hrdata_q <= 32'h0000_0000;
		end
		else
		begin
			wr_pend_q <= ahb_go && HWRITE_I;
			if (ahb_go)
				waddr_q <= HADDR_I[7:0];
			hrdata_q <= 32'h0000_0000;
			if (ahb_go && !HWRITE_I)
			begin
				// unmapped addresses read as zero
				if (HADDR_I[7:0] < blt_pkg::OFF_WIDTH && HADDR_I[1:0] == 2'h0)
					hrdata_q <= gpr_q[HADDR_I[blt_pkg::GPR_IDX_HI:blt_pkg::GPR_IDX_LO]];
				else if (HADDR_I[7:0] == blt_pkg::OFF_WIDTH)
					hrdata_q <= {16'h0000, width_q};
				else if (HADDR_I[7:0] == blt_pkg::OFF_STAT)
				begin
					hrdata_q[blt_pkg::STAT_LFLAG] <= lflag_q;
					hrdata_q[blt_pkg::STAT_BUSY] <= BUSY_O;
				end
			end
		end
	end

	// ==========================================
	// memory master
	// signed warps and steps set the direction
	assign step = (kind_q == blt_pkg::K_EXT) ? gpr_q[4] :
		(dec_q ? -blt_pkg::STEP_WORD : blt_pkg::STEP_WORD);
	assign ack = MEM_REQ_O && MEM_ACK_I;

	// request, address, size and write data per state
	always_comb
	begin
		MEM_REQ_O = 1'b0;
		MEM_WE_O = 1'b0;
		MEM_ADDR_O = gpr_q[0];
		MEM_SIZE_O = blt_pkg::SZ_WORD;
		MEM_WDATA_O = 32'h0000_0000;
		case (state_q)
			S_PRE, S_SRC: MEM_REQ_O = 1'b1;
			S_DRD:
			begin
				MEM_REQ_O = 1'b1;
				MEM_ADDR_O = gpr_q[1];
			end
			S_DRD_HI:
			begin
				MEM_REQ_O = 1'b1;
				MEM_ADDR_O = gpr_q[1] + blt_pkg::STEP_WORD;
			end
			S_DWR:
			begin
				MEM_REQ_O = 1'b1;
				MEM_WE_O = 1'b1;
				MEM_ADDR_O = gpr_q[1];
				if (kind_q == blt_pkg::K_EXT)
					MEM_WDATA_O = {16'h0000, BLIT_DATA_I};
				else if (kind_q == blt_pkg::K_WT)
					MEM_WDATA_O = {16'h0000, wt_res[15:0]};
				else
					MEM_WDATA_O = {16'h0000, merged};
			end
			S_DWR_HI:
			begin
				MEM_REQ_O = 1'b1;
				MEM_WE_O = 1'b1;
				MEM_ADDR_O = gpr_q[1] + blt_pkg::STEP_WORD;
				MEM_WDATA_O = {16'h0000, wt_res[31:16]};
			end
			S_PAT:
			begin
				MEM_REQ_O = gpr_q[2] != 32'h0000_0000;
				MEM_WE_O = 1'b1;
				MEM_SIZE_O = psize_q;
				MEM_WDATA_O = gpr_q[3];
			end
			default: MEM_REQ_O = 1'b0;
		endcase
	end

	// ==========================================
	// data path of the masked operations and the word transfer
	always_comb
	begin
		// same two masks on every line
		mask_w = (first_q ? gpr_q[4][15:0] : blt_pkg::MASK_ALL) &
			(wcnt_q == 16'h0001 ? gpr_q[5][15:0] : blt_pkg::MASK_ALL);
		// shift joins words in walk order
		if (dec_q)
			aligned = 16'({carry_q, src_q} >> gpr_q[2][3:0]);
		else
			aligned = 16'({src_q, carry_q} >> (5'(blt_pkg::WORD_W) - {1'b0, gpr_q[2][3:0]}));
		merged = (combine(op_q, aligned, dst_q) & mask_w) | (dst_q & ~mask_w);
		// OR into the destination double word
		wt_res = {dhi_q, dst_q} | ({16'h0000, src_q} << gpr_q[2][4:0]);
	end

	// ==========================================
	// engine and register file
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			state_q <= S_IDLE;
			kind_q <= blt_pkg::K_NONE;
			for (int i = 0; i < 8; i++)
				gpr_q[i] <= 32'h0000_0000;
			width_q <= 16'h0000;
			lflag_q <= 1'b0;
			op_q <= 4'h0;
			dec_q <= 1'b0;
			inv_q <= 1'b0;
			psize_q <= blt_pkg::SZ_WORD;
			wcnt_q <= 16'h0000;
			first_q <= 1'b0;
			src_q <= 16'h0000;
			carry_q <= 16'h0000;
			dst_q <= 16'h0000;
			dhi_q <= 16'h0000;
		end
		else
		begin
			// software writes only land while idle, so operands stay put
			if (wr_pend_q && state_q == S_IDLE)
			begin
				if (waddr_q < blt_pkg::OFF_WIDTH && waddr_q[1:0] == 2'h0)
					gpr_q[waddr_q[blt_pkg::GPR_IDX_HI:blt_pkg::GPR_IDX_LO]] <= HWDATA_I;
				else if (waddr_q == blt_pkg::OFF_WIDTH)
					width_q <= HWDATA_I[15:0];
				else if (waddr_q == blt_pkg::OFF_STAT)
					lflag_q <= HWDATA_I[blt_pkg::STAT_LFLAG];
			end
			case (state_q)
				S_IDLE:
				begin
					if (start && new_kind != blt_pkg::K_NONE)
					begin
						kind_q <= new_kind;
						// operands from registers and stack top
						op_q <= HWDATA_I[blt_pkg::OP_HI:blt_pkg::OP_LO];
						dec_q <= HWDATA_I[blt_pkg::DIR_BIT] && new_kind == blt_pkg::K_MASK;
						inv_q <= HWDATA_I[blt_pkg::INV_BIT] && new_kind == blt_pkg::K_MASK;
						if (HWDATA_I[blt_pkg::OP_HI:blt_pkg::OP_LO] == blt_pkg::OP_FOR)
						begin
							dec_q <= 1'b0;
							inv_q <= 1'b0;
						end
						psize_q <= HWDATA_I[blt_pkg::SZ_HI:blt_pkg::SZ_LO];
						if (new_kind == blt_pkg::K_WT)
							state_q <= S_SRC;
						else if (new_kind == blt_pkg::K_PAT)
							state_q <= S_PAT;
						else
							state_q <= S_LINE;
					end
				end
				S_LINE:
				begin
					first_q <= 1'b1;
					carry_q <= 16'h0000;
					// width is source words per line
					wcnt_q <= width_q;
					gpr_q[5] <= (kind_q == blt_pkg::K_EXT) ? gpr_q[2] : gpr_q[5];
					if (gpr_q[3] == 32'h0000_0000)
						state_q <= S_IDLE;
					else if (kind_q == blt_pkg::K_MASK && width_q == 16'h0000)
						state_q <= S_EOL;
					// preload read only while L is clear
					else if (kind_q == blt_pkg::K_EXT && !lflag_q)
						state_q <= S_PRE;
					else
						state_q <= S_SRC;
				end
				S_PRE:
				begin
					if (ack)
					begin
						gpr_q[0] <= gpr_q[0] + step;
						state_q <= S_SRC;
					end
				end
				S_SRC:
				begin
					if (ack)
					begin
						src_q <= inv_q ? ~MEM_RDATA_I[15:0] : MEM_RDATA_I[15:0];
						// any byte address is fetched as is
						if (kind_q != blt_pkg::K_WT)
							gpr_q[0] <= gpr_q[0] + step;
						state_q <= S_DRD;
					end
				end
				S_DRD:
				begin
					if (ack)
					begin
						dst_q <= MEM_RDATA_I[15:0];
						state_q <= (kind_q == blt_pkg::K_WT) ? S_DRD_HI : S_DWR;
					end
				end
				S_DRD_HI:
				begin
					if (ack)
					begin
						dhi_q <= MEM_RDATA_I[15:0];
						state_q <= S_DWR;
					end
				end
				S_DWR:
				begin
					if (ack)
					begin
						first_q <= 1'b0;
						carry_q <= src_q;
						wcnt_q <= wcnt_q - 16'h0001;
						// masked and external: read, read, write until line ends; word transfer goes on to its high write
						if (kind_q == blt_pkg::K_WT)
							state_q <= S_DWR_HI;
						else if (kind_q == blt_pkg::K_EXT)
						begin
							gpr_q[1] <= gpr_q[1] + step;
							gpr_q[5] <= gpr_q[5] - blt_pkg::STEP_WORD;
							state_q <= ($signed(gpr_q[5]) <= $signed(blt_pkg::STEP_WORD)) ?
								S_EOL : S_SRC;
						end
						else
						begin
							gpr_q[1] <= gpr_q[1] + step;
							state_q <= (wcnt_q == 16'h0001) ? S_EOL : S_SRC;
						end
					end
				end
				S_DWR_HI:
				begin
					if (ack)
					begin
						gpr_q[0] <= gpr_q[0] + blt_pkg::STEP_WORD;
						gpr_q[1] <= gpr_q[1] + blt_pkg::STEP_WORD;
						state_q <= S_IDLE;
					end
				end
				S_EOL:
				begin
					// pointers end past last plus warp
					gpr_q[0] <= gpr_q[0] + gpr_q[6];
					gpr_q[1] <= gpr_q[1] + gpr_q[7];
					gpr_q[3] <= gpr_q[3] - 32'h0000_0001;
					state_q <= S_LINE;
				end
				S_PAT:
				begin
					// R0 stays on the last store
					if (gpr_q[2] == 32'h0000_0000)
						state_q <= S_IDLE;
					else if (ack)
					begin
						gpr_q[2] <= gpr_q[2] - 32'h0000_0001;
						if (gpr_q[2] != 32'h0000_0001)
							gpr_q[0] <= gpr_q[0] + gpr_q[1];
					end
				end
				default: state_q <= S_IDLE;
			endcase
		end
	end

	// ==========================================
	// assertions
	a_mask_keep: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		(state_q == S_DWR && kind_q == blt_pkg::K_MASK) |->
		((MEM_WDATA_O[15:0] & ~mask_w) == (dst_q & ~mask_w)))
		else $error("masked-off destination bit changed");
	a_mask_stable: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		(kind_q == blt_pkg::K_MASK && BUSY_O && $past(BUSY_O)) |->
		($stable(gpr_q[4]) && $stable(gpr_q[5])))
		else $error("edge mask changed during operation");
	a_fast_or_opts: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		(kind_q == blt_pkg::K_MASK && op_q == blt_pkg::OP_FOR && BUSY_O) |-> (!dec_q && !inv_q))
		else $error("fast OR ran with an option");
	a_pat_end: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		(state_q == S_PAT && ack && gpr_q[2] == 32'h0000_0001) |=>
		(gpr_q[2] == 32'h0000_0000 && $stable(gpr_q[0])) ##1 state_q == S_IDLE)
		else $error("pattern store end state wrong");
	a_pat_step: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		(state_q == S_PAT && ack && gpr_q[2] > 32'h0000_0001) |=>
		gpr_q[0] == $past(gpr_q[0]) + $past(gpr_q[1]))
		else $error("pattern address not stepped");
	a_wt_advance: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		(state_q == S_DWR_HI && ack) |=>
		(gpr_q[0] == $past(gpr_q[0]) + 32'h0000_0002 && state_q == S_IDLE))
		else $error("word transfer did not advance by two");
	a_ext_preload: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		(state_q == S_LINE && kind_q == blt_pkg::K_EXT && gpr_q[3] != 32'h0000_0000) |=>
		(state_q == (lflag_q ? S_SRC : S_PRE)))
		else $error("preload read choice wrong");
	a_ext_keep: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		(kind_q == blt_pkg::K_EXT && BUSY_O && $past(BUSY_O)) |->
		($stable(gpr_q[4]) && $stable(gpr_q[6]) && $stable(gpr_q[7])))
		else $error("external transfer changed a kept register");
	a_dec_walk: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		(state_q == S_DWR && kind_q == blt_pkg::K_MASK && dec_q && ack) |=>
		gpr_q[1] == $past(gpr_q[1]) - 32'h0000_0002)
		else $error("decreasing walk did not step back");
	a_rw_order: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		(state_q == S_SRC && ack && kind_q != blt_pkg::K_WT) |=>
		(state_q == S_DRD && !MEM_WE_O))
		else $error("destination read did not follow source read");
endmodule

// file: tb/sys_mem_model.sv
`timescale 1ns/1ns
// ==========================================
// system memory behind the engine's master port
module sys_mem_model
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// request side
	input wire logic req_i,
	input wire logic we_i,
	input wire logic [31:0] addr_i,
	input wire logic [1:0] size_i,
	input wire logic [31:0] wdata_i,
	// idle cycles before each ack
	input wire logic [1:0] lat_i,
	// answer side
	output logic [31:0] rdata_o,
	output logic ack_o
);
	// byte store, preset by the bench
	logic [7:0] mem [int unsigned];
	// served reads and writes
	int rd_cnt;
	int wr_cnt;
	// wait-state counter
	logic [1:0] wait_q;
	// unwritten bytes read as zero
	function automatic logic [7:0] peek(input int unsigned a);
		return mem.exists(a) ? mem[a] : 8'h00;
	endfunction
	// one access per request; data only valid on the ack edge
	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			ack_o <= 1'b0;
			wait_q <= 2'h0;
			rdata_o <= 32'h0;
		end
		else if (req_i && ack_o)
		begin
			// access completes on this edge
			ack_o <= 1'b0;
			rdata_o <= ~rdata_o;
			if (we_i)
			begin
				for (int i = 0; i <= int'(size_i); i++)
					mem[addr_i + i] = wdata_i[8*i +: 8];
				wr_cnt++;
			end
			else
				rd_cnt++;
		end
		else if (req_i && wait_q == lat_i)
		begin
			// answer after the chosen latency
			ack_o <= 1'b1;
			wait_q <= 2'h0;
			rdata_o <= {peek(addr_i + 3), peek(addr_i + 2), peek(addr_i + 1), peek(addr_i)};
		end
		else
		begin
			// released data lines toggle so stale values never look valid
			rdata_o <= ~rdata_o;
			wait_q <= req_i ? wait_q + 2'h1 : 2'h0;
		end
	end
endmodule

// file: tb/bitblt_pattern_instr_unit_tb.sv
`timescale 1ns/1ns
// ==========================================
// self-checking bench for the blit instruction unit
module bitblt_pattern_instr_unit_tb;
	logic clk, rst_n, hwrite, hready, hresp, mem_req, mem_we, mem_ack, busy;
	logic [1:0] htrans, mem_size, lat;
	logic [31:0] haddr, hwdata, hrdata, mem_addr, mem_wdata, mem_rdata;
	logic [15:0] blit;
	// golden memory image
	logic [7:0] gm [int unsigned];
	int num_errors, samples_checked, cyc;
	// ==========================================
	// design and memory
	bitblt_pattern_instr_unit dut_u (.CORE_CLK_I(clk), .RST_N_I(rst_n), .HSEL_I(1'b1),
		.HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2),
		.HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready),
		.HRESP_O(hresp), .MEM_REQ_O(mem_req), .MEM_WE_O(mem_we), .MEM_ADDR_O(mem_addr),
		.MEM_SIZE_O(mem_size), .MEM_WDATA_O(mem_wdata), .MEM_RDATA_I(mem_rdata),
		.MEM_ACK_I(mem_ack), .BLIT_DATA_I(blit), .BUSY_O(busy));
	sys_mem_model mem_u (.clk_i(clk), .rst_n_i(rst_n), .req_i(mem_req), .we_i(mem_we),
		.addr_i(mem_addr), .size_i(mem_size), .wdata_i(mem_wdata), .lat_i(lat),
		.rdata_o(mem_rdata), .ack_o(mem_ack));
	// ==========================================
	// clock and hang guard
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			num_errors++;
			conclude();
		end
	end
	// ==========================================
	// helpers
	task automatic conclude();
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one single ahb transfer, plus an idle cycle after it
	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk); while (hready !== 1'b1);
		rd = hrdata;
		@(posedge clk);
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] v);
		logic [31:0] x;
		ahb(1'b1, a, v, x);
	endtask
	task automatic chkreg(input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] x;
		ahb(1'b0, a, 32'h0, x);
		chk("register", exp, x);
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask
	// wait for the engine, bounded
	task automatic finish_op();
		for (int n = 0; n < 5000 && busy !== 1'b0; n++)
			@(posedge clk);
		chk("busy", 32'h0, {31'h0, busy});
	endtask
	task automatic put16(input int unsigned a, input logic [15:0] v);
		gm[a] = v[7:0];
		gm[a + 1] = v[15:8];
		mem_u.mem[a] = v[7:0];
		mem_u.mem[a + 1] = v[15:8];
	endtask
	function automatic logic [15:0] g16(input int unsigned a);
		return {gm[a + 1], gm[a]};
	endfunction
	task automatic fill(input int unsigned a, input int n);
		for (int i = 0; i < n; i += 2)
			put16(a + i, 16'($urandom));
	endtask
	task automatic cmp_region(input int unsigned a, input int n);
		for (int i = 0; i < n; i++)
			chk("memory byte", {24'h0, gm[a + i]}, {24'h0, mem_u.mem[a + i]});
	endtask
	// ==========================================
	// main sequence
	initial
	begin
		logic [3:0] ops [5];
		logic [15:0] s, t, r, m4, m5, cy, al;
		logic [31:0] pat, dw;
		int vs, st, off, sb, db, sh, rd0, wr0, z;
		logic down, inv, fo;
		ops = '{blt_pkg::OP_AND, blt_pkg::OP_OR, blt_pkg::OP_XOR, blt_pkg::OP_FOR, blt_pkg::OP_COPY};
		rst_n = 1'b0;
		htrans = 2'h0;
		haddr = 32'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		lat = 2'h0;
		blit = 16'h0;
		void'($urandom(69834));
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		// every register and an unmapped word read zero after reset
		for (int a = 0; a <= 'h2C; a += 4)
			chkreg(32'(a), 32'h0);
		// masked ops: every function, both directions, random source sense
		for (int f = 0; f < 5; f++)
			for (int k = 0; k < 2; k++)
			begin
				fo = (f == 3);
				down = k[0];
				inv = 1'($urandom);
				vs = $urandom % 2 ? 16 : -16;
				st = (down && !fo) ? -2 : 2;
				off = (down && !fo) ? 4 : 0;
				sb = vs < 0 ? 'h1010 : 'h1000;
				db = sb + 'h1000;
				lat <= 2'($urandom);
				fill(32'h1000, 32);
				fill(32'h2000, 32);
				// masks given against the destination words
				m4 = 16'($urandom);
				m5 = 16'($urandom);
				wr(32'h0, 32'(sb + off));
				wr(32'h4, 32'(db + off));
				sh = $urandom % 16;
				wr(32'h8, 32'(sh));
				wr(32'hC, 32'h2);
				wr(32'h10, {16'h0, m4});
				wr(32'h14, {16'h0, m5});
				wr(32'h18, 32'(vs - st * 3));
				wr(32'h1C, 32'(vs - st * 3));
				wr(32'h20, 32'h3);
				for (int l = 0; l < 2; l++)
					for (int j = 0; j < 3; j++)
					begin
						s = g16(sb + off + l * vs + j * st);
						t = g16(db + off + l * vs + j * st);
						if (inv && !fo)
							s = ~s;
						// shift joins word with previous one
						if (j == 0)
							cy = 16'h0;
						al = (down && !fo) ? 16'({cy, s} >> sh) : 16'({s, cy} >> (16 - sh));
						cy = s;
						case (f)
							0: r = al & t;
							2: r = al ^ t;
							4: r = al;
							default: r = al | t;
						endcase
						r = j == 0 ? (r & m4) | (t & ~m4) : j == 2 ? (r & m5) | (t & ~m5) : r;
						gm[db + off + l * vs + j * st] = r[7:0];
						gm[db + off + l * vs + j * st + 1] = r[15:8];
					end
				// op and size codes, selector only for and
				wr({24'h0, blt_pkg::OFF_INSTR}, {14'h0, down, f == 0, inv, 1'b0, ops[f],
					f == 0 ? blt_pkg::SZ_DWORD : blt_pkg::SZ_WORD, blt_pkg::MASKED_CODE});
				finish_op();
				cmp_region(32'h2000, 32);
			end
		// and code without its selector must not start
		wr({24'h0, blt_pkg::OFF_INSTR},
			{16'h0, 2'h0, blt_pkg::OP_AND, blt_pkg::SZ_DWORD, blt_pkg::MASKED_CODE});
		chk("busy", 32'h0, {31'h0, busy});
		cmp_region(32'h2000, 32);
		// shifted word or transfer
		fill(32'h1000, 4);
		fill(32'h2000, 4);
		sh = $urandom % 16;
		wr(32'h0, 32'h1000);
		wr(32'h4, 32'h2000);
		wr(32'h8, 32'(sh));
		dw = {g16(32'h2002), g16(32'h2000)} | ({16'h0, g16(32'h1000)} << sh);
		for (int b = 0; b < 4; b++)
			gm[32'h2000 + b] = dw[8 * b +: 8];
		wr({24'h0, blt_pkg::OFF_INSTR}, {24'h0, blt_pkg::WT_CODE});
		finish_op();
		cmp_region(32'h2000, 4);
		chkreg(32'h0, 32'h1002);
		chkreg(32'h4, 32'h2002);
		// pattern store in every size, stepping downward
		for (int q = 0; q < 3; q++)
		begin
			z = q == 2 ? 3 : q;
			fill(32'h3028, 40);
			pat = $urandom;
			lat <= 2'h3;
			wr(32'h0, 32'h3048);
			wr(32'h4, 32'hFFFF_FFF8);
			wr(32'h8, 32'h4);
			wr(32'hC, pat);
			for (int m = 0; m < 4; m++)
				for (int b = 0; b <= z; b++)
					gm[32'h3048 - 8 * m + b] = pat[8 * b +: 8];
			wr({24'h0, blt_pkg::OFF_INSTR}, {22'h0, 2'(z), blt_pkg::PAT_CODE});
			chkreg({24'h0, blt_pkg::OFF_STAT}, 32'h2);
			// a register write while running is dropped
			wr(32'hC, ~pat);
			finish_op();
			cmp_region(32'h3028, 40);
			chkreg(32'h0, 32'h3030);
			chkreg(32'h4, 32'hFFFF_FFF8);
			chkreg(32'h8, 32'h0);
			chkreg(32'hC, pat);
		end
		// external transfer, preload on and off, both directions
		for (int k = 0; k < 2; k++)
		begin
			st = k ? -2 : 2;
			fill(32'h1000, 32);
			fill(32'h2000, 32);
			lat <= 2'($urandom);
			// blit unit loaded before the start
			blit <= 16'($urandom);
			wr(32'h0, 32'h1000 + 2 * k);
			wr(32'h4, 32'h2000 + 2 * k);
			wr(32'h8, 32'h4);
			wr(32'hC, 32'h2);
			wr(32'h10, 32'(st));
			wr(32'h14, 32'h0);
			wr(32'h18, 32'(16 - 2 * st));
			wr(32'h1C, 32'(16 - 2 * st));
			wr({24'h0, blt_pkg::OFF_STAT}, 32'(k));
			@(posedge clk);
			for (int a = 0; a < 4; a++)
			begin
				gm[32'h2000 + (a / 2) * 16 + (a % 2) * 2] = blit[7:0];
				gm[32'h2001 + (a / 2) * 16 + (a % 2) * 2] = blit[15:8];
			end
			rd0 = mem_u.rd_cnt;
			wr0 = mem_u.wr_cnt;
			wr({24'h0, blt_pkg::OFF_INSTR}, {24'h0, blt_pkg::EXT_CODE});
			finish_op();
			cmp_region(32'h2000, 32);
			chk("read count", 32'(k ? 8 : 10), 32'(mem_u.rd_cnt - rd0));
			chk("write count", 32'h4, 32'(mem_u.wr_cnt - wr0));
			chkreg(32'h0, 32'(k ? 'h1022 : 'h1024));
			chkreg(32'h4, 32'('h2020 + 2 * k));
			chkreg(32'h10, 32'(st));
			chkreg(32'h18, 32'(16 - 2 * st));
			chkreg(32'h1C, 32'(16 - 2 * st));
		end
		conclude();
	end
endmodule
